// file: shared/diag_flag_pkg.sv
// constants and carrier types of the diagnostic flag interrupt unit
package diag_flag_pkg;
    // ------------------------------------------------------------
    // flag indices
    // ------------------------------------------------------------
    localparam int NUM_FLAGS    = 20;
    localparam int F_VDD_OVER   = 0;
    localparam int F_VDD_UNDER  = 1;
    localparam int F_DATA_ACC   = 2;
    localparam int F_PROTOCOL   = 3;
    localparam int F_SHD_DOUBLE = 4;
    localparam int F_SHD_SINGLE = 5;
    localparam int F_NVM_DOUBLE = 6;
    localparam int F_NVM_SINGLE = 7;
    localparam int F_OSC_RANGE  = 8;
    localparam int F_OSC_STUCK  = 9;
    localparam int F_SUPPLY_PIN = 10;
    localparam int F_LOW_AMP    = 11;
    localparam int F_BUS_FAIL   = 12;
    localparam int F_WATCHDOG   = 13;
    localparam int F_MECH       = 14;
    localparam int F_BUF_OFFSET = 15;
    localparam int F_BUF_LOAD   = 16;
    localparam int F_COIL_SHORT = 17;
    localparam int F_COIL_TWO   = 18;
    localparam int F_COIL_ONE   = 19;
    // held until power-on reset / evaluated during start-up only
    localparam logic [NUM_FLAGS-1:0] STATIC_MASK  = 20'h26050;
    localparam logic [NUM_FLAGS-1:0] STARTUP_MASK = 20'h200C0;
    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int POS_W  = 4;
    localparam int OSC_W  = 12;
    localparam int WD_W   = 16;
    localparam int CNT_W  = 10;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int STARTUP_NS      = 20000;
    localparam int TIMEBASE_NS     = 10000;
    localparam int STARTUP_CYCLES  = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEBASE_CYCLES = TIMEBASE_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 writeLock;
        logic                 incrementalMode;
        logic                 i2cIrqMode;
        logic                 diagSignal;
        logic                 diagHigh;
        logic [NUM_FLAGS-1:0] irqEnable;
        logic [WD_W-1:0]      watchdogValue;
        logic [OSC_W-1:0]     oscUpper;
        logic [OSC_W-1:0]     oscLower;
    } cfg_s;
    typedef struct packed {
        logic       vddAboveSet;
        logic       vddAboveRelease;
        logic       vddBelowSet;
        logic       vddBelowRelease;
        logic       dataAccessFail;
        logic       supplyPinFault;
        logic       lowAmplitude;
        logic       busFail;
        logic       mechDamage;
        logic       bufferOffset;
        logic       bufferOverload;
        logic       coilShort;
        logic [2:0] coilOneFault;
        logic [2:0] coilTwoFault;
        logic       txOscillator;
    } sense_s;
    typedef struct packed {
        logic              oneBit;
        logic              twoBit;
        logic [POS_W-1:0]  errPos;
        logic [WORD_W-1:0] word;
    } ecc_s;
    typedef struct packed {
        logic hold;
        logic levelHigh;
    } hs_drive_s;
endpackage

// file: design/diagnostic_flag_interrupt_unit.sv
// diagnostic flag collection, interrupt pin and diagnostic output state
//
// Functional notes
// (R1) write lock set: every later configuration write is refused
// (R2) each detected fault sets its own readable diagnostic flag
// (R3) per-flag enable decides whether it raises an interrupt event
// (R4) diagnostic signalling on: interrupt forces sine/cosine pins low or high
// (R5) static flags stay set until power-on reset
// (R6) temporary flags clear once their cause is gone
// (R7) continuous checks run always; start-up checks only after reset
// (R8) shadow bank: double error static flag, single error temporary flag
// (R9) single-bit errors in shadow bank or memory are corrected at output
// (R10) start-up memory words checked: double static, single temporary flag
// (R11) nonzero watchdog runs periodic timer; expiry sets static flag; zero stops
// (R12) coil-to-coil short tested once after reset, held until reset
// (R13) oscillator frequency measured; outside limits sets temporary flag
// (R14) stopped oscillator sets temporary stuck flag
// (R15) supply over/under flags with hysteresis against toggling
// (R16) failed serial transfer sets temporary protocol flag
// (R17) incremental mode low amplitude flag; host then raises gain
// (R18) output pair mean away from half supply sets buffer flag
// (R19) each receive coil short or open sets its coil flag
// (R20) analog supply low or pin over-voltage sets temporary flag
// (R21) interrupt configuration drives the alert pin push-pull
// (R22) alert pin low while any enabled flag is active
`timescale 1ns/10ps
module diagnostic_flag_interrupt_unit
    import diag_flag_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 cfgWrite,
    input  wire cfg_s                 cfgWriteData,
    input  wire sense_s               sense,
    input  wire logic                 protocolFail,
    input  wire ecc_s                 shadowCheck,
    input  wire ecc_s                 nvmCheck,
    input  wire logic                 nvmWordValid,
    output cfg_s                      cfgActive,
    output logic                      writeRefused,
    output logic [NUM_FLAGS-1:0]      flags,
    output logic [OSC_W-1:0]          oscCount,
    output logic                      startupDone,
    output logic [WORD_W-1:0]         shadowCorrected,
    output logic [WORD_W-1:0]         nvmCorrected,
    output logic                      selectOrAlertPinOut,
    output logic                      selectOrAlertPinOe,
    output hs_drive_s                 highSpeedDrive
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sense_s               senseMeta;
    sense_s               senseSync;
    logic [CNT_W-1:0]     startupCount;
    logic [CNT_W-1:0]     tbCount;
    logic [OSC_W-1:0]     edgeCount;
    logic                 oscPrev;
    logic                 oscEdge;
    logic                 oscValid;
    logic [WD_W-1:0]      wdCount;
    logic                 wdExpire;
    logic [NUM_FLAGS-1:0] cond;
    logic                 alertNow;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            senseMeta <= '0;
            senseSync <= '0;
        end
        else
        begin
            senseMeta <= sense;
            senseSync <= senseMeta;
        end
    end

    // ------------------------------------------------------------
    // configuration and write lock
    // ------------------------------------------------------------
    // the lock bit is part of the stored word, so once set it can never be written back
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfgActive    <= '0;
            writeRefused <= 1'b0;
        end
        else
        begin
            if (cfgWrite && !cfgActive.writeLock)
                cfgActive <= cfgWriteData; // R1
            writeRefused <= cfgWrite && cfgActive.writeLock; // R1
        end
    end

    // ------------------------------------------------------------
    // start-up window
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            startupCount <= '0;
            startupDone  <= 1'b0;
        end
        else if (!startupDone)
        begin
            startupCount <= startupCount + CNT_W'(1);
            startupDone  <= (startupCount == CNT_W'(STARTUP_CYCLES - 1)); // R7
        end
    end

    // ------------------------------------------------------------
    // oscillator time base
    // ------------------------------------------------------------
    // edges faster than half of ref_clk alias; the tx range stays well below
    assign oscEdge = senseSync.txOscillator && !oscPrev;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            oscPrev   <= 1'b0;
            tbCount   <= '0;
            edgeCount <= '0;
            oscCount  <= '0;
            oscValid  <= 1'b0;
        end
        else
        begin
            oscPrev <= senseSync.txOscillator;
            if (tbCount == CNT_W'(TIMEBASE_CYCLES - 1))
            begin
                tbCount   <= '0;
                oscCount  <= edgeCount + OSC_W'(oscEdge); // R13
                edgeCount <= '0;
                oscValid  <= 1'b1;
            end
            else
            begin
                tbCount   <= tbCount + CNT_W'(1);
                edgeCount <= edgeCount + OSC_W'(oscEdge);
            end
        end
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wdCount  <= '0;
            wdExpire <= 1'b0;
        end
        else if (cfgActive.watchdogValue == '0)
        begin
            wdCount  <= '0; // R11
            wdExpire <= 1'b0;
        end
        else if (wdCount >= cfgActive.watchdogValue - WD_W'(1))
        begin
            wdCount  <= '0; // R11
            wdExpire <= 1'b1;
        end
        else
        begin
            wdCount  <= wdCount + WD_W'(1);
            wdExpire <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // single-bit correction
    // ------------------------------------------------------------
    // a double error is only flagged; the word passes uncorrected
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shadowCorrected <= '0;
            nvmCorrected    <= '0;
        end
        else
        begin
            shadowCorrected <= shadowCheck.word
                ^ ((shadowCheck.oneBit && !shadowCheck.twoBit) ?
                   (WORD_W'(1) << shadowCheck.errPos) : '0); // R9
            if (nvmWordValid)
                nvmCorrected <= nvmCheck.word
                    ^ ((nvmCheck.oneBit && !nvmCheck.twoBit) ?
                       (WORD_W'(1) << nvmCheck.errPos) : '0); // R9
        end
    end

    // ------------------------------------------------------------
    // fault conditions
    // ------------------------------------------------------------
    always_comb
    begin
        cond = '0;
        cond[F_VDD_OVER]   = senseSync.vddAboveSet
            || (flags[F_VDD_OVER] && senseSync.vddAboveRelease); // R15
        cond[F_VDD_UNDER]  = senseSync.vddBelowSet
            || (flags[F_VDD_UNDER] && senseSync.vddBelowRelease); // R15
        cond[F_DATA_ACC]   = senseSync.dataAccessFail; // R2
        cond[F_PROTOCOL]   = protocolFail; // R16
        cond[F_SHD_DOUBLE] = shadowCheck.twoBit; // R8
        cond[F_SHD_SINGLE] = shadowCheck.oneBit; // R8
        cond[F_NVM_DOUBLE] = nvmWordValid && nvmCheck.twoBit; // R10
        cond[F_NVM_SINGLE] = nvmWordValid ? nvmCheck.oneBit : flags[F_NVM_SINGLE]; // R10
        cond[F_OSC_RANGE]  = oscValid
            && (oscCount > cfgActive.oscUpper || oscCount < cfgActive.oscLower); // R13
        cond[F_OSC_STUCK]  = oscValid && (oscCount == '0); // R14
        cond[F_SUPPLY_PIN] = senseSync.supplyPinFault; // R20
        cond[F_LOW_AMP]    = senseSync.lowAmplitude && cfgActive.incrementalMode; // R17
        cond[F_BUS_FAIL]   = senseSync.busFail;
        cond[F_WATCHDOG]   = wdExpire; // R11
        cond[F_MECH]       = senseSync.mechDamage;
        cond[F_BUF_OFFSET] = senseSync.bufferOffset; // R18
        cond[F_BUF_LOAD]   = senseSync.bufferOverload;
        cond[F_COIL_SHORT] = senseSync.coilShort; // R12
        cond[F_COIL_TWO]   = |senseSync.coilTwoFault; // R19
        cond[F_COIL_ONE]   = |senseSync.coilOneFault; // R19
    end

    // ------------------------------------------------------------
    // flag registers
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_FLAGS; i++)
    begin : g_flag
        always_ff @(posedge ref_clk or negedge reset_n)
        begin
            if (!reset_n)
                flags[i] <= 1'b0;
            else if (STARTUP_MASK[i] && startupDone)
                flags[i] <= flags[i]; // R7
            else if (STATIC_MASK[i])
                flags[i] <= flags[i] || cond[i]; // R5
            else
                flags[i] <= cond[i]; // R6
        end
    end

    // ------------------------------------------------------------
    // interrupt outputs
    // ------------------------------------------------------------
    assign alertNow = |(flags & cfgActive.irqEnable); // R3

    // outside interrupt mode the pin is an input for select or address strap
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            selectOrAlertPinOut <= 1'b1;
            selectOrAlertPinOe  <= 1'b0;
            highSpeedDrive      <= '0;
        end
        else
        begin
            selectOrAlertPinOut      <= !alertNow; // R22
            selectOrAlertPinOe       <= cfgActive.i2cIrqMode; // R21
            highSpeedDrive.hold      <= cfgActive.diagSignal && alertNow; // R4
            highSpeedDrive.levelHigh <= cfgActive.diagHigh; // R4
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_lock;
        cfgActive.writeLock && cfgWrite |=> $stable(cfgActive) && writeRefused;
    endproperty
    a_lock: assert property (p_lock) else $error("locked write changed config"); // R1
    property p_static;
        flags[F_MECH] |=> flags[F_MECH] [*8];
    endproperty
    a_static: assert property (p_static) else $error("static flag cleared"); // R5
    property p_proto;
        protocolFail |=> flags[F_PROTOCOL] ##1 (flags[F_PROTOCOL] == $past(protocolFail));
    endproperty
    a_proto: assert property (p_proto) else $error("protocol flag wrong"); // R16
    property p_temp;
        !senseSync.bufferOffset |=> !flags[F_BUF_OFFSET];
    endproperty
    a_temp: assert property (p_temp) else $error("temporary flag stuck"); // R6
    property p_startup;
        startupDone |=> $stable(flags[F_COIL_SHORT]) && $stable(flags[F_NVM_SINGLE]);
    endproperty
    a_startup: assert property (p_startup) else $error("start-up flag moved"); // R7
    property p_correct;
        shadowCheck.oneBit && !shadowCheck.twoBit |=>
            (shadowCorrected ^ $past(shadowCheck.word))
                == (WORD_W'(1) << $past(shadowCheck.errPos));
    endproperty
    a_correct: assert property (p_correct) else $error("shadow word not corrected"); // R9
    // the counter restarts at the expiry edge itself, so it reads zero alongside the pulse
    property p_wd;
        wdExpire |-> (wdCount == '0) ##1 flags[F_WATCHDOG];
    endproperty
    a_wd: assert property (p_wd) else $error("watchdog expiry lost"); // R11
    property p_wd_stop;
        cfgActive.watchdogValue == '0 |=> wdCount == '0 && !wdExpire;
    endproperty
    a_wd_stop: assert property (p_wd_stop) else $error("watchdog runs at zero"); // R11
    property p_osc;
        oscValid && oscCount > cfgActive.oscUpper |=> flags[F_OSC_RANGE];
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator range missed"); // R13
    property p_alert;
        |(flags & cfgActive.irqEnable) |=> !selectOrAlertPinOut;
    endproperty
    a_alert: assert property (p_alert) else $error("alert pin not low"); // R22
    property p_hs;
        cfgActive.diagSignal && alertNow |=> highSpeedDrive.hold;
    endproperty
    a_hs: assert property (p_hs) else $error("outputs not forced"); // R4
    property p_oe;
        cfgActive.i2cIrqMode |=> selectOrAlertPinOe;
    endproperty
    a_oe: assert property (p_oe) else $error("alert pin not driven"); // R21

    c_alert: cover property (alertNow ##1 !selectOrAlertPinOut);
    c_wd: cover property (wdExpire ##1 flags[F_WATCHDOG]);
    c_lock: cover property (cfgActive.writeLock && cfgWrite);
    c_hyst: cover property (flags[F_VDD_OVER] && !senseSync.vddAboveSet);
endmodule

// file: verification/alert_host_model.sv
// host-side model: resolves the alert line and reacts to a low amplitude flag
`timescale 1ns/10ps
module alert_host_model
    import diag_flag_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 pinOut,
    input  wire logic                 pinOe,
    input  wire logic [NUM_FLAGS-1:0] flags,
    output logic                      pinLevel,
    output logic                      gainRequest
);
    // ------------------------------------------------------------
    // alert line
    // ------------------------------------------------------------
    // pull-up holds the line high whenever the device lets go of it
    assign pinLevel = pinOe ? pinOut : 1'b1;
    // ------------------------------------------------------------
    // gain handling
    // ------------------------------------------------------------
    // the host answers a low amplitude flag by asking for more gain
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            gainRequest <= 1'b0;
        else
            gainRequest <= flags[F_LOW_AMP];
    end
endmodule

// file: verification/diagnostic_flag_interrupt_unit_tb.sv
// self-checking testbench of the diagnostic flag interrupt unit
`timescale 1ns/10ps
module diagnostic_flag_interrupt_unit_tb
    import diag_flag_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                 ref_clk;
    logic                 reset_n;
    logic                 cfgWrite;
    cfg_s                 cfgWriteData;
    sense_s               sense;
    logic                 protocolFail;
    ecc_s                 shadowCheck;
    ecc_s                 nvmCheck;
    logic                 nvmWordValid;
    cfg_s                 cfgActive;
    logic                 writeRefused;
    logic [NUM_FLAGS-1:0] flags;
    logic [OSC_W-1:0]     oscCount;
    logic                 startupDone;
    logic [WORD_W-1:0]    shadowCorrected;
    logic [WORD_W-1:0]    nvmCorrected;
    logic                 pinOut;
    logic                 pinOe;
    hs_drive_s            hsDrive;
    logic                 pinLevel;
    logic                 gainRequest;
    logic                 oscRun;
    cfg_s                 base;
    cfg_s                 c;
    int                   n_fail;
    int                   compares;
    int                   cycles;

    diagnostic_flag_interrupt_unit diagnostic_flag_interrupt_unit_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .cfgWrite(cfgWrite),
        .cfgWriteData(cfgWriteData), .sense(sense), .protocolFail(protocolFail),
        .shadowCheck(shadowCheck), .nvmCheck(nvmCheck), .nvmWordValid(nvmWordValid),
        .cfgActive(cfgActive), .writeRefused(writeRefused), .flags(flags),
        .oscCount(oscCount), .startupDone(startupDone), .shadowCorrected(shadowCorrected),
        .nvmCorrected(nvmCorrected), .selectOrAlertPinOut(pinOut),
        .selectOrAlertPinOe(pinOe), .highSpeedDrive(hsDrive));

    alert_host_model alert_host_model_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .pinOut(pinOut), .pinOe(pinOe),
        .flags(flags), .pinLevel(pinLevel), .gainRequest(gainRequest));

    // ------------------------------------------------------------
    // clock, transmit oscillator, timeout
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // oscillator square wave at half the clock rate, stopped on demand
    always @(posedge ref_clk)
        if (oscRun)
            sense.txOscillator <= ~sense.txOscillator;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // sample a little after the edge so registered outputs have landed
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input cfg_s d);
        @(posedge ref_clk);
        cfgWrite     <= 1'b1;
        cfgWriteData <= d;
        @(posedge ref_clk);
        cfgWrite <= 1'b0;
        #1;
    endtask
    task automatic doReset;
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        step(1);
        chk(flags, '0);
        chk({pinOut, pinOe, pinLevel, hsDrive}, 5'b10100);
        chk(cfgActive, '0);
    endtask
    task automatic nvmPulse(input logic s, input logic d, input logic [15:0] w);
        @(posedge ref_clk);
        nvmCheck     <= '{oneBit: s, twoBit: d, errPos: 4'h3, word: w};
        nvmWordValid <= 1'b1;
        @(posedge ref_clk);
        nvmWordValid <= 1'b0;
        step(1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_nvm;
        @(posedge ref_clk);
        sense.coilShort <= 1'b1;
        wr(base);
        chk(cfgActive, base);
        chk(startupDone, 1'b0);
        nvmPulse(1'b1, 1'b0, 16'h00F0);
        chk(nvmCorrected, 16'h00F8);
        chk(flags[F_NVM_SINGLE], 1'b1);
        nvmPulse(1'b0, 1'b1, 16'h1234);
        chk(flags[F_NVM_DOUBLE], 1'b1);
        chk(flags[F_COIL_SHORT], 1'b1);
        @(posedge ref_clk);
        sense.coilShort <= 1'b0;
        for (int k = 0; k < 1100 && startupDone !== 1'b1; k++)
            step(1);
        chk(startupDone, 1'b1);
        // start-up checks are frozen once the window has closed
        nvmPulse(1'b1, 1'b0, 16'h0000);
        chk(flags[F_NVM_SINGLE], 1'b0);
    endtask

    task automatic t_alert;
        for (int h = 1; h >= 0; h--)
        begin
            c = base;
            c.diagHigh = h[0];
            wr(c);
            @(posedge ref_clk);
            protocolFail <= 1'b1;
            step(3);
            chk(flags[F_PROTOCOL], 1'b1);
            chk({pinOut, pinOe, pinLevel}, 3'b010);
            chk(hsDrive, {1'b1, h[0]});
            @(posedge ref_clk);
            protocolFail <= 1'b0;
            step(3);
            chk(flags[F_PROTOCOL], 1'b0);
            chk({pinOut, hsDrive.hold}, 2'b10);
        end
        // internal bus failure is flagged but not enabled as an event
        @(posedge ref_clk);
        sense.busFail <= 1'b1;
        step(4);
        chk({flags[F_BUS_FAIL], pinOut}, 2'b11);
        @(posedge ref_clk);
        sense.busFail <= 1'b0;
    endtask

    task automatic t_static;
        @(posedge ref_clk);
        sense.mechDamage <= 1'b1;
        sense.coilShort  <= 1'b1;
        shadowCheck      <= '{oneBit: 1'b0, twoBit: 1'b1, errPos: 4'h0, word: 16'hA5A5};
        repeat (2) @(posedge ref_clk);
        sense.mechDamage <= 1'b0;
        shadowCheck      <= '{oneBit: 1'b1, twoBit: 1'b0, errPos: 4'h0, word: 16'hA5A5};
        step(4);
        chk(flags[F_MECH], 1'b1);
        chk(flags[F_SHD_DOUBLE], 1'b1);
        chk(flags[F_SHD_SINGLE], 1'b1);
        chk(shadowCorrected, 16'hA5A4);
        chk(flags[F_COIL_SHORT], 1'b1);
        @(posedge ref_clk);
        shadowCheck     <= '0;
        sense.coilShort <= 1'b0;
        step(3);
        chk({flags[F_SHD_DOUBLE], flags[F_SHD_SINGLE]}, 2'b10);
    endtask

    task automatic t_sense;
        // hysteresis: the release comparator alone keeps the flag up
        @(posedge ref_clk);
        sense.vddAboveSet <= 1'b1;
        sense.vddAboveRelease <= 1'b1;
        sense.vddBelowSet <= 1'b1;
        sense.supplyPinFault <= 1'b1;
        sense.bufferOffset <= 1'b1;
        @(posedge ref_clk);
        sense.vddAboveSet <= 1'b0;
        sense.vddBelowSet <= 1'b0;
        step(4);
        chk(flags[1:0], 2'b01);
        chk({flags[F_SUPPLY_PIN], flags[F_BUF_OFFSET]}, 2'b11);
        @(posedge ref_clk);
        sense.vddAboveRelease <= 1'b0;
        sense.supplyPinFault <= 1'b0;
        sense.bufferOffset <= 1'b0;
        sense.lowAmplitude <= 1'b1;
        step(4);
        chk({flags[F_VDD_OVER], flags[F_SUPPLY_PIN], flags[F_BUF_OFFSET]}, 3'b000);
        chk(flags[F_LOW_AMP], 1'b0);
        c = base;
        c.incrementalMode = 1'b1;
        wr(c);
        for (int k = 0; k < 10 && gainRequest !== 1'b1; k++)
            step(1);
        chk(gainRequest, 1'b1);
        @(posedge ref_clk);
        sense.lowAmplitude <= 1'b0;
        step(4);
        chk(flags[F_LOW_AMP], 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge ref_clk);
            sense.coilOneFault <= 3'h1 << i;
            step(4);
            chk({flags[F_COIL_ONE], flags[F_COIL_TWO]}, 2'b10);
            @(posedge ref_clk);
            sense.coilOneFault <= '0;
            sense.coilTwoFault <= 3'h1 << i;
            step(4);
            chk({flags[F_COIL_ONE], flags[F_COIL_TWO]}, 2'b01);
            @(posedge ref_clk);
            sense.coilTwoFault <= '0;
        end
    endtask

    task automatic t_osc;
        // waits span two time-base windows so one whole window follows each change
        wr(base);
        oscRun <= 1'b1;
        step(1100);
        chk(oscCount > 12'h0F0 && oscCount < 12'h104, 1'b1);
        chk(flags[F_OSC_STUCK:F_OSC_RANGE], 2'b00);
        c = base;
        c.oscUpper = 12'h0C8;
        wr(c);
        step(1100);
        chk(flags[F_OSC_RANGE], 1'b1);
        wr(base);
        oscRun <= 1'b0;
        step(1100);
        chk(oscCount, 12'h000);
        chk(flags[F_OSC_STUCK], 1'b1);
    endtask

    task automatic t_wd_lock;
        c = base;
        c.watchdogValue = 16'h000A;
        wr(c);
        step(3);
        chk(flags[F_WATCHDOG], 1'b0);
        step(12);
        chk(flags[F_WATCHDOG], 1'b1);
        c.watchdogValue = 16'h0000;
        c.writeLock = 1'b1;
        wr(c);
        chk(cfgActive, c);
        chk(flags[F_WATCHDOG], 1'b1);
        wr(base);
        chk({writeRefused, cfgActive}, {1'b1, c});
        doReset();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        reset_n = 1'b0;
        cfgWrite = 1'b0;
        cfgWriteData = '0;
        sense = '0;
        protocolFail = 1'b0;
        shadowCheck = '0;
        nvmCheck = '0;
        nvmWordValid = 1'b0;
        oscRun = 1'b0;
        n_fail = 0;
        compares = 0;
        cycles = 0;
        base = '0;
        base.irqEnable[F_PROTOCOL] = 1'b1;
        base.i2cIrqMode = 1'b1;
        base.diagSignal = 1'b1;
        base.oscLower = 12'h064;
        base.oscUpper = 12'h12C;
        doReset();
        t_nvm();
        t_alert();
        t_static();
        t_sense();
        t_osc();
        t_wd_lock();
        summarize();
    end
endmodule
